// ==== logic/cam_table_defs.vh ====
`ifndef CAM_TABLE_DEFS_VH
`define CAM_TABLE_DEFS_VH
// register indices of the object dictionary entries
`define REG_REQ_STATE    16'h2300
`define REG_CAM_CONFIG   16'h2360
`define REG_RESERVE_SIZE 16'h250a
`define REG_RAM_POINTER  16'h250b
`define REG_DATA_WINDOW  16'h250c
// capture ram geometry
`define RAM_WORDS        2048
`define RAM_AW           11
`define META_ENTRIES     16
`define META_WORDS       32
// configuration fields
`define CFG_TABLE_LSB    0
`define CFG_USE_RAM_BIT  7
`define CFG_INPUT_LSB    8
`define CFG_TRIG_LSB     12
// compressed marker bits of the first data word
`define CMP_SET_BIT      14
`define CMP_CLR_BIT      15
// state code that enters camming
`define STATE_CAMMING    16'h0019
// trigger encodings
`define TRIG_CONT        2'h0
`define TRIG_EDGE        2'h1
`define TRIG_LEVEL       2'h2
`define TRIG_INDEX       2'h3
// reset values
`define RST_REQ_STATE    16'h0000
`define RST_CAM_CONFIG   16'h0000
`define RST_RESERVE      16'h0000
`define RST_POINTER      16'h0000
`endif

// ==== logic/cam_fifo.v ====
`timescale 1ns/10ps
module cam_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clk,
  input  wire             srst,
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output wire             inReady,
  output wire [WIDTH-1:0] outData,
  output wire             outValid,
  input  wire             outReady
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr_q;
  reg [AW-1:0]    rdPtr_q;
  reg [AW:0]      count_q;
  wire            push;
  wire            pop;

  assign inReady  = (count_q != DEPTH[AW:0]);
  assign outValid = (count_q != {(AW+1){1'b0}});
  assign outData  = mem[rdPtr_q];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  always @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
    if (srst) begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_q + 1'b1;
      end
      if (push & ~pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop & ~push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule // cam_fifo

// ==== logic/cam_table_ram_store.v ====
`timescale 1ns/10ps
`include "cam_table_defs.vh"
module cam_table_ram_store #(
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW    = 2,
  parameter NUM_INPUTS = 16
) (
  input  wire                  clk,
  input  wire                  srst,
  input  wire                  regWrite,
  input  wire                  regRead,
  input  wire [15:0]           regIndex,
  input  wire [31:0]           regWdata,
  output reg  [31:0]           regRdata,
  output reg                   regRvalid,
  output reg                   regReady,
  input  wire [NUM_INPUTS-1:0] inputPins,
  input  wire                  masterIndex,
  output reg                   cammingActive,
  output reg                   useFlash,
  output reg  [3:0]            flashTable,
  output reg                   stepValid,
  output reg  [15:0]           masterStep,
  output reg  [15:0]           slaveStep,
  input  wire                  stepReady,
  output reg                   tableRunning
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_META0 = 3'h1;
  localparam ST_META1 = 3'h2;
  localparam ST_FIRST = 3'h3;
  localparam ST_WAIT  = 3'h4;
  localparam ST_MSTR  = 3'h5;
  localparam ST_SLV   = 3'h6;

  reg [15:0] ram [0:`RAM_WORDS-1];

  reg [15:0] reqState_q;
  reg [15:0] camConfig_q;
  reg [15:0] reserve_q;
  reg [15:0] pointer_q;
  reg [2:0]  state_q;
  reg [15:0] startOff_q;
  reg [15:0] length_q;
  reg [15:0] rdAddr_q;
  reg [15:0] left_q;
  reg        compressed_q;
  reg [15:0] constMaster_q;
  reg [15:0] pendMaster_q;
  reg [15:0] ramQ_q;
  reg [NUM_INPUTS-1:0] pinMeta_q;
  reg [NUM_INPUTS-1:0] pinSync_q;
  reg        idxMeta_q;
  reg        idxSync_q;
  reg        trigPrev_q;
  reg        idxPrev_q;
  reg [15:0] rdAddr_d;

  wire       isCamming;
  wire       ramMode;
  wire [3:0] tableSel;
  wire [1:0] trigKind;
  wire [3:0] inSel;
  wire       trigLevel;
  wire       trigRise;
  wire       idxRise;
  wire       winWrite;
  wire       winRead;
  wire       fifoInReady;
  wire       fifoOutValid;
  wire [31:0] fifoOutData;
  reg        pushValid;
  reg [31:0] pushData;
  wire       runOk;
  wire       trigFire;

  function [10:0] ramAddr;
    input [15:0] off;
    begin
      ramAddr = off[`RAM_AW-1:0];
    end
  endfunction

  function isCompressed;
    input [15:0] word;
    begin
      isCompressed = word[`CMP_SET_BIT] & ~word[`CMP_CLR_BIT];
    end
  endfunction

  assign isCamming = (reqState_q == `STATE_CAMMING);
  assign ramMode   = camConfig_q[`CFG_USE_RAM_BIT];
  assign tableSel  = camConfig_q[`CFG_TABLE_LSB+3:`CFG_TABLE_LSB];
  assign trigKind  = camConfig_q[`CFG_TRIG_LSB+1:`CFG_TRIG_LSB];
  assign inSel     = camConfig_q[`CFG_INPUT_LSB+3:`CFG_INPUT_LSB];
  assign trigLevel = pinSync_q[inSel];
  assign trigRise  = trigLevel & ~trigPrev_q;
  assign idxRise   = idxSync_q & ~idxPrev_q;
  assign winWrite  = regWrite & (regIndex == `REG_DATA_WINDOW);
  assign winRead   = regRead & (regIndex == `REG_DATA_WINDOW);
  assign runOk     = isCamming & ramMode;
  assign trigFire  = (trigKind == `TRIG_CONT) |
                     ((trigKind == `TRIG_EDGE) & trigRise) |
                     ((trigKind == `TRIG_LEVEL) & trigLevel) |
                     ((trigKind == `TRIG_INDEX) & idxRise);
  // level trigger pauses playback when the input drops
  wire levelHold   = (trigKind == `TRIG_LEVEL) & ~trigLevel;

  // register access; host window writes share the ram with playback, which reads ram[rdAddr_d] every cycle
  always @(posedge clk) begin
    if (winWrite) begin
      ram[ramAddr(pointer_q)] <= regWdata[15:0];
    end
    ramQ_q <= ram[ramAddr(rdAddr_d)]; // next address, so ramQ_q always matches rdAddr_q
  end

  always @(posedge clk) begin
    if (srst) begin
      reqState_q  <= `RST_REQ_STATE;
      camConfig_q <= `RST_CAM_CONFIG;
      reserve_q   <= `RST_RESERVE;
      pointer_q   <= `RST_POINTER;
      regRdata    <= 32'h00000000;
      regRvalid   <= 1'b0;
      regReady    <= 1'b0;
    end else begin
      regRvalid <= regRead;
      regReady  <= regRead | regWrite;
      if (regWrite) begin
        case (regIndex)
          `REG_REQ_STATE:    reqState_q  <= regWdata[15:0];
          `REG_CAM_CONFIG:   camConfig_q <= regWdata[15:0];
          `REG_RESERVE_SIZE: reserve_q   <= regWdata[15:0];
          `REG_RAM_POINTER:  pointer_q   <= regWdata[15:0];
          `REG_DATA_WINDOW:  pointer_q   <= pointer_q + 16'h0001;
          default: begin
          end
        endcase
      end else if (winRead) begin
        pointer_q <= pointer_q + 16'h0001;
      end
      if (regRead) begin
        case (regIndex)
          `REG_REQ_STATE:    regRdata <= {16'h0000, reqState_q};
          `REG_CAM_CONFIG:   regRdata <= {16'h0000, camConfig_q};
          `REG_RESERVE_SIZE: regRdata <= {16'h0000, reserve_q};
          `REG_RAM_POINTER:  regRdata <= {16'h0000, pointer_q};
          `REG_DATA_WINDOW:  regRdata <= {{16{ram[ramAddr(pointer_q)][15]}},
                                          ram[ramAddr(pointer_q)]};
          default:           regRdata <= 32'h00000000;
        endcase
      end
    end
  end

  // trigger inputs come from pins, so two flops before use
  always @(posedge clk) begin
    if (srst) begin
      pinMeta_q  <= {NUM_INPUTS{1'b0}};
      pinSync_q  <= {NUM_INPUTS{1'b0}};
      idxMeta_q  <= 1'b0;
      idxSync_q  <= 1'b0;
      trigPrev_q <= 1'b0;
      idxPrev_q  <= 1'b0;
    end else begin
      pinMeta_q  <= inputPins;
      pinSync_q  <= pinMeta_q;
      idxMeta_q  <= masterIndex;
      idxSync_q  <= idxMeta_q;
      trigPrev_q <= trigLevel;
      idxPrev_q  <= idxSync_q;
    end
  end

  always @* begin
    pushValid = 1'b0;
    pushData  = {constMaster_q, ramQ_q};
    if (state_q == ST_SLV && !levelHold) begin
      pushValid = 1'b1;
      pushData  = compressed_q ? {constMaster_q, ramQ_q} : {pendMaster_q, ramQ_q};
    end
  end

  // next read address; holding it keeps ramQ_q on the same word while stalled
  always @* begin
    rdAddr_d = rdAddr_q;
    if (runOk) begin
      case (state_q)
        ST_IDLE: begin
          rdAddr_d = {11'h000, tableSel, 1'b0};
        end
        ST_META0: begin
          rdAddr_d = {11'h000, tableSel, 1'b1};
        end
        ST_META1: begin
          rdAddr_d = startOff_q;
        end
        ST_WAIT: begin
          if (trigFire) begin
            rdAddr_d = isCompressed(ramQ_q) ? startOff_q + 16'h0001 : startOff_q;
          end
        end
        ST_MSTR: begin
          rdAddr_d = rdAddr_q + 16'h0001;
        end
        ST_SLV: begin
          if (fifoInReady && !levelHold) begin
            rdAddr_d = rdAddr_q + 16'h0001;
          end
        end
        default: begin
          rdAddr_d = rdAddr_q;
        end
      endcase
    end
  end

  // playback: ramQ_q shows ram[rdAddr_q], one cycle after each state picks rdAddr_d
  always @(posedge clk) begin
    if (srst) begin
      state_q       <= ST_IDLE;
      startOff_q    <= 16'h0000;
      length_q      <= 16'h0000;
      rdAddr_q      <= 16'h0000;
      left_q        <= 16'h0000;
      compressed_q  <= 1'b0;
      constMaster_q <= 16'h0000;
      pendMaster_q  <= 16'h0000;
      cammingActive <= 1'b0;
      useFlash      <= 1'b0;
      flashTable    <= 4'h0;
      tableRunning  <= 1'b0;
    end else begin
      rdAddr_q      <= rdAddr_d;
      cammingActive <= isCamming;
      useFlash      <= isCamming & ~ramMode;
      flashTable    <= tableSel;
      tableRunning  <= (state_q == ST_MSTR) | (state_q == ST_SLV) | (state_q == ST_WAIT);
      if (!runOk) begin
        state_q <= ST_IDLE;
      end else begin
        case (state_q)
          ST_IDLE: begin
            state_q <= ST_META0;
          end
          ST_META0: begin
            startOff_q <= ramQ_q;
            state_q    <= ST_META1;
          end
          ST_META1: begin
            length_q <= ramQ_q;
            state_q  <= ST_FIRST;
          end
          ST_FIRST: begin
            // the word at the start offset stands in ramQ_q from here on
            state_q <= ST_WAIT;
          end
          ST_WAIT: begin
            compressed_q  <= isCompressed(ramQ_q);
            constMaster_q <= ramQ_q;
            left_q        <= length_q;
            if (trigFire) begin
              if (length_q == 16'h0000) begin
                state_q <= ST_IDLE;
              end else if (isCompressed(ramQ_q)) begin
                left_q  <= length_q - 16'h0001;
                state_q <= (length_q == 16'h0001) ? ST_IDLE : ST_SLV;
              end else begin
                state_q <= ST_MSTR;
              end
            end
          end
          ST_MSTR: begin
            // index pulses here are ignored since only ST_WAIT looks at them
            pendMaster_q <= ramQ_q;
            if (left_q < 16'h0002) begin
              state_q <= ST_IDLE; // odd trailing master word dropped
            end else begin
              left_q  <= left_q - 16'h0001;
              state_q <= ST_SLV;
            end
          end
          ST_SLV: begin
            if (fifoInReady && !levelHold) begin
              left_q <= left_q - 16'h0001;
              if (left_q == 16'h0001) begin
                state_q <= ST_IDLE;
              end else begin
                state_q <= compressed_q ? ST_SLV : ST_MSTR;
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // compressed rows read one word per cycle; in ST_SLV the read address moves only on push
  cam_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk      (clk),
    .srst     (srst | ~runOk), // leaving camming drops queued pairs
    .inData   (pushData),
    .inValid  (pushValid & fifoInReady),
    .inReady  (fifoInReady),
    .outData  (fifoOutData),
    .outValid (fifoOutValid),
    .outReady (~stepValid | stepReady)
  );

  always @(posedge clk) begin
    if (srst) begin
      stepValid  <= 1'b0;
      masterStep <= 16'h0000;
      slaveStep  <= 16'h0000;
    end else if (~stepValid | stepReady) begin
      stepValid  <= fifoOutValid; // values passed on as relative steps
      masterStep <= fifoOutData[31:16];
      slaveStep  <= fifoOutData[15:0];
    end
  end
endmodule // cam_table_ram_store

// ==== verif/cam_table_ram_store_asserts.sv ====
`timescale 1ns/10ps
`include "cam_table_defs.vh"
module cam_table_ram_store_asserts #(
  parameter NUM_INPUTS = 16
) (
  input wire                  clk,
  input wire                  srst,
  input wire                  regWrite,
  input wire                  regRead,
  input wire [15:0]           regIndex,
  input wire [31:0]           regWdata,
  input wire [31:0]           regRdata,
  input wire                  regRvalid,
  input wire                  regReady,
  input wire [NUM_INPUTS-1:0] inputPins,
  input wire                  masterIndex,
  input wire                  cammingActive,
  input wire                  useFlash,
  input wire [3:0]            flashTable,
  input wire                  stepValid,
  input wire [15:0]           masterStep,
  input wire [15:0]           slaveStep,
  input wire                  stepReady,
  input wire                  tableRunning
);
  reg [15:0] ptr_q;
  reg [3:0]  cfgTbl_q;
  wire       winHit = (regWrite || regRead) && regIndex == `REG_DATA_WINDOW;
  // shadow pointer, so a read of it can be checked against every window access
  always @(posedge clk) begin
    if (srst)
      ptr_q <= 16'h0000;
    else if (regWrite && regIndex == `REG_RAM_POINTER)
      ptr_q <= regWdata[15:0];
    else if (winHit)
      ptr_q <= ptr_q + 16'h0001;
    if (regWrite && regIndex == `REG_CAM_CONFIG)
      cfgTbl_q <= regWdata[3:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  access_ready_a: assert property ((regWrite || regRead) |=> regReady)
    else $error("no ready after register access");
  pointer_read_a: assert property (regRead && regIndex == `REG_RAM_POINTER
    |=> regRvalid && regRdata[15:0] == $past(ptr_q)) else $error("pointer readback wrong");
  enter_cam_a: assert property (regWrite && regIndex == `REG_REQ_STATE
    && regWdata[15:0] == `STATE_CAMMING |-> ##[1:2] cammingActive)
    else $error("camming not entered");
  leave_cam_a: assert property (regWrite && regIndex == `REG_REQ_STATE
    && regWdata[15:0] != `STATE_CAMMING |-> ##[1:2] !cammingActive)
    else $error("camming not left");
  step_source_a: assert property ($rose(stepValid)
    |-> $past(cammingActive) && !$past(useFlash)) else $error("step without ram camming");
  step_hold_a: assert property (stepValid && !stepReady
    |=> stepValid && $stable(masterStep) && $stable(slaveStep)) else $error("step not held");
  table_sel_a: assert property (regWrite && regIndex == `REG_CAM_CONFIG
    |-> ##2 flashTable == cfgTbl_q) else $error("table number not copied");
  flash_sel_a: assert property (useFlash |-> cammingActive || $past(cammingActive))
    else $error("flash selected outside camming");
endmodule // cam_table_ram_store_asserts

bind cam_table_ram_store cam_table_ram_store_asserts #(.NUM_INPUTS(NUM_INPUTS))
  cam_table_ram_store_asserts_i (.clk, .srst, .regWrite, .regRead, .regIndex, .regWdata,
  .regRdata, .regRvalid, .regReady, .inputPins, .masterIndex, .cammingActive, .useFlash,
  .flashTable, .stepValid, .masterStep, .slaveStep, .stepReady, .tableRunning);

// ==== verif/host_model.sv ====
`timescale 1ns/10ps
module host_model (
  input  wire        clk,
  input  wire [31:0] regRdata,
  output reg         regWrite,
  output reg         regRead,
  output reg  [15:0] regIndex,
  output reg  [31:0] regWdata
);
  initial begin
    regWrite = 1'b0;
    regRead  = 1'b0;
    regIndex = 16'h0000;
    regWdata = 32'h0;
  end
  // ready cycle passes before the next access, so pulses never merge
  task wr(input [15:0] idx, input [31:0] dat);
    begin
      @(posedge clk);
      #1;
      regIndex = idx;
      regWdata = dat;
      regWrite = 1'b1;
      @(posedge clk);
      #1;
      regWrite = 1'b0;
      regWdata = ~dat;
      @(posedge clk);
    end
  endtask
  task rd(input [15:0] idx, output [31:0] dat);
    begin
      @(posedge clk);
      #1;
      regIndex = idx;
      regRead  = 1'b1;
      @(posedge clk);
      #1;
      regRead = 1'b0;
      @(posedge clk);
      dat = regRdata;
    end
  endtask
endmodule // host_model

// ==== verif/cam_table_ram_store_tb.sv ====
`timescale 1ns/10ps
`include "cam_table_defs.vh"
module cam_table_ram_store_tb;
  reg         clk;
  reg         srst;
  reg  [15:0] inputPins;
  reg         masterIndex;
  reg         stepReady;
  wire        regWrite, regRead, regRvalid, regReady, cammingActive, useFlash;
  wire        stepValid, tableRunning;
  wire [15:0] regIndex, masterStep, slaveStep;
  wire [31:0] regWdata, regRdata;
  wire [3:0]  flashTable;
  reg  [15:0] lfsrState = 16'h0059;
  reg  [15:0] tw [0:7];
  reg  [31:0] rdv;
  reg  [15:0] m, s;
  integer     err_total = 0;
  integer     compares = 0;
  integer     t, k;
  cam_table_ram_store cam_table_ram_store_i (.clk, .srst, .regWrite, .regRead, .regIndex,
    .regWdata, .regRdata, .regRvalid, .regReady, .inputPins, .masterIndex, .cammingActive,
    .useFlash, .flashTable, .stepValid, .masterStep, .slaveStep, .stepReady, .tableRunning);
  host_model host_model_i (.clk, .regRdata, .regWrite, .regRead, .regIndex, .regWdata);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [15:0] rnd();
    lfsrState = {lfsrState[14:0], lfsrState[15] ^ lfsrState[13] ^ lfsrState[12] ^ lfsrState[10]};
    return lfsrState;
  endfunction
  // table 0 is compressed (3 slaves), table 1 standard (2 rows); both repeat
  function automatic logic [31:0] expPair(input integer tb, input integer kk);
    return tb ? {tw[4 + 2 * (kk % 2)], tw[5 + 2 * (kk % 2)]} : {tw[0], tw[1 + kk % 3]};
  endfunction
  task end_of_test();
    begin
      $display("comparisons %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input string what, input [31:0] exp, input [31:0] got);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("BAD %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task take();
    integer n;
    begin
      repeat (rnd() % 3 + 1) @(posedge clk);
      #1 stepReady = 1'b1;
      n = 0;
      @(negedge clk);
      while (stepValid !== 1'b1 && n < 300) begin
        n = n + 1;
        @(negedge clk);
      end
      if (n >= 300) begin
        err_total = err_total + 1;
        end_of_test();
      end
      m = masterStep;
      s = slaveStep;
      @(posedge clk);
      #1 stepReady = 1'b0;
    end
  endtask
  // consumer stays ready while camming stops, so no pair is left hanging
  task stopCam();
    begin
      @(posedge clk);
      #1 stepReady = 1'b1;
      host_model_i.wr(`REG_REQ_STATE, 32'h0);
      repeat (12) @(posedge clk);
      #1 stepReady = 1'b0;
      chk("no step after stop", 0, stepValid);
    end
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    err_total = err_total + 1;
    end_of_test();
  end
  initial begin
    srst = 1'b1;
    stepReady = 1'b0;
    inputPins = 16'h0;
    masterIndex = 1'b0;
    repeat (2) @(posedge clk);
    #1 srst = 1'b0;
    chk("camming after reset", 0, cammingActive);
    host_model_i.wr(`REG_RESERVE_SIZE, 32'd200);
    host_model_i.wr(`REG_RAM_POINTER, 32'h0);
    for (k = 0; k < 4; k++)
      host_model_i.wr(`REG_DATA_WINDOW, k[0] ? 32'd4 : 32'd40 + 2 * k);
    for (k = 0; k < 8; k++)
      tw[k] = rnd();
    tw[0][15:14] = 2'b01;
    tw[4][14] = 1'b0;
    host_model_i.wr(`REG_RAM_POINTER, 32'd40);
    for (k = 0; k < 8; k++)
      host_model_i.wr(`REG_DATA_WINDOW, {16'h0, tw[k]});
    host_model_i.wr(`REG_RAM_POINTER, 32'd40);
    for (k = 0; k < 8; k++) begin
      host_model_i.rd(`REG_DATA_WINDOW, rdv);
      chk("window word", tw[k], rdv[15:0]);
    end
    host_model_i.rd(`REG_RAM_POINTER, rdv);
    chk("pointer", 48, rdv[15:0]);
    for (t = 0; t < 2; t++) begin
      host_model_i.wr(`REG_CAM_CONFIG, 32'h80 | t);
      host_model_i.wr(`REG_REQ_STATE, 32'd25);
      for (k = 0; k < 7; k++) begin
        take();
        chk("step pair", expPair(t, k), {m, s});
      end
      stopCam();
    end
    for (t = 1; t < 4; t++) begin
      host_model_i.wr(`REG_CAM_CONFIG, (t << 12) | 32'h281);
      host_model_i.wr(`REG_REQ_STATE, 32'd25);
      repeat (30) @(posedge clk);
      #1;
      chk("idle before trigger", 0, stepValid);
      chk("armed while waiting", 1, tableRunning);
      if (t == 3) masterIndex = 1'b1;
      else inputPins[2] = 1'b1;
      take();
      chk("triggered pair", expPair(1, 0), {m, s});
      inputPins = 16'h0;
      masterIndex = 1'b0;
      stopCam();
    end
    host_model_i.wr(`REG_CAM_CONFIG, 32'h3);
    host_model_i.wr(`REG_REQ_STATE, 32'd25);
    repeat (20) @(posedge clk);
    #1;
    chk("flash select", 1, useFlash);
    chk("flash table", 3, flashTable);
    chk("no ram steps", 0, stepValid);
    chk("no playback", 0, tableRunning);
    end_of_test();
  end
endmodule // cam_table_ram_store_tb
